// ---- hw/rtc_cfg_regs.sv ----
// APB register logic: configuration/calibration, power control and the value-register window.
// Assumes calendar counters live outside; they supply field values and take write strobes.
// Assumes one bus clock; half_sec_set, sync_busy and pwr_ctrl_req come from logic on that clock.
// Assumes presetn is the power-on reset only; no other reset source reaches this block.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Pointer selects month/weekday/minutes high, year/day/hours/seconds low; 11 high reserved.
// - Config/calibration register resets only on power-on reset.
// - Module enable write accepted only while value write enable is 1.
// - Half-second status read-only, cleared by write of minutes/seconds low byte.
// - Eight-bit calibration field in bits 7..0; +127 pulses per 15 seconds max.
// - Power-control output driven only when enabled; polarity picks active level.
// - Pointer decrements on each high value register access, stopping at 00.
// - Value register writes blocked while write enable is 0.
module rtc_cfg_regs (
    input  wire logic        pclk,             // Bus clock
    input  wire logic        presetn,          // Power-on reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB access phase
    input  wire logic        pwrite,           // APB direction
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    input  wire logic [3:0]  pstrb,            // APB byte strobes
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error
    input  wire logic [15:0] val_high_in,      // Calendar field, high window
    input  wire logic [15:0] val_low_in,       // Calendar field, low window
    input  wire logic        half_sec_set,     // Pulse: second half of second began
    input  wire logic        sync_busy,        // Rollover ripple in progress
    input  wire logic        pwr_ctrl_req,     // Power window active, from time base
    output logic      [15:0] val_wdata,        // Value write data
    output logic      [1:0]  val_wptr,         // Window pointer of the write
    output logic             val_high_wr,      // Pulse: high value write
    output logic             val_low_wr,       // Pulse: low value write
    output logic             prescale_reset,   // Pulse: minutes/seconds low byte written
    output logic             module_enable,    // Clock module enable
    output logic             output_enable,    // Clock output enable
    output logic signed [7:0] cal_value,       // Signed drift calibration per window
    output logic      [1:0]  clk_source_sel,   // Time base source select
    output logic      [1:0]  out_source_sel,   // Output source select
    output logic             stab_prescale,    // Stability window prescale
    output logic             samp_prescale,    // Sample window prescale
    output logic             pwr_ctrl_out,     // Power-control pin level
    output logic             pwr_ctrl_oe       // Power-control pin drive enable
);
    // Configuration/calibration and power-control state
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic [15:0] pwr_reg;
    logic [15:0] pwr_next;

    // Value-register write path towards the calendar counters
    logic [15:0] val_wdata_reg;
    logic [15:0] val_wdata_next;
    logic [1:0]  val_wptr_reg;
    logic [1:0]  val_wptr_next;
    logic        hi_wr_reg;
    logic        hi_wr_next;
    logic        lo_wr_reg;
    logic        lo_wr_next;
    logic        pre_rst_reg;
    logic        pre_rst_next;

    // Read path
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Bus phase decode
    logic        access;
    logic        wr;
    logic        rd_setup;
    logic        known;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign access = psel && penable;
    assign wr     = access && pwrite;
    // Read data is captured at the end of the setup phase, so that the registered
    // prdata already stands during the access phase, when pready is high.
    // Costs nothing in wait states; the value is that of the setup cycle.
    assign rd_setup = psel && !penable && !pwrite;
    assign known  = (paddr == rtc_cfg_pkg::OFF_CFG_CAL) ||
                    (paddr == rtc_cfg_pkg::OFF_PWR_CTRL) ||
                    (paddr == rtc_cfg_pkg::OFF_VAL_HIGH) ||
                    (paddr == rtc_cfg_pkg::OFF_VAL_LOW) ||
                    (paddr == rtc_cfg_pkg::OFF_STATUS);

    // Writes and pointer steps take effect at the access edge only; a read that is
    // refused for an unmapped address still returns zero.

    always_comb begin
        logic [15:0] m;
        logic        wen;
        logic        ptr_hit;
        m              = merge16(cfg_reg, pwdata, pstrb);
        wen            = cfg_reg[rtc_cfg_pkg::BIT_WR_EN];
        cfg_next       = cfg_reg;
        pwr_next       = pwr_reg;
        val_wdata_next = val_wdata_reg;
        val_wptr_next  = val_wptr_reg;
        hi_wr_next     = 1'b0;
        lo_wr_next     = 1'b0;
        pre_rst_next   = 1'b0;
        prdata_next    = prdata_reg;
        ptr_hit        = 1'b0;
        if (wr && paddr == rtc_cfg_pkg::OFF_CFG_CAL) begin
            cfg_next[rtc_cfg_pkg::BIT_WR_EN]  = m[rtc_cfg_pkg::BIT_WR_EN];
            cfg_next[rtc_cfg_pkg::BIT_OUT_EN] = m[rtc_cfg_pkg::BIT_OUT_EN];
            cfg_next[rtc_cfg_pkg::PTR_LSB +: 2] = m[rtc_cfg_pkg::PTR_LSB +: 2];
            cfg_next[rtc_cfg_pkg::CAL_LSB +: 8] = m[rtc_cfg_pkg::CAL_LSB +: 8];
            if (wen) begin
                cfg_next[rtc_cfg_pkg::BIT_MOD_EN] = m[rtc_cfg_pkg::BIT_MOD_EN];
            end
        end
        if (wr && paddr == rtc_cfg_pkg::OFF_PWR_CTRL) begin
            pwr_next = merge16(pwr_reg, pwdata, pstrb) & rtc_cfg_pkg::PWR_WMASK;
        end
        if (access && paddr == rtc_cfg_pkg::OFF_VAL_HIGH) begin
            ptr_hit = 1'b1;
        end
        if (wr && wen && paddr == rtc_cfg_pkg::OFF_VAL_HIGH) begin
            val_wdata_next = pwdata[15:0];
            val_wptr_next  = cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2];
            hi_wr_next     = 1'b1;
        end
        if (wr && wen && paddr == rtc_cfg_pkg::OFF_VAL_LOW) begin
            val_wdata_next = pwdata[15:0];
            val_wptr_next  = cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2];
            lo_wr_next     = 1'b1;
            if (cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2] == rtc_cfg_pkg::PTR_MIN_SEC && pstrb[0]) begin
                pre_rst_next = 1'b1;
            end
        end
        // Set wins over the clear: the hardware event lands after the software clear
        if (pre_rst_next) begin
            cfg_next[rtc_cfg_pkg::BIT_HALF_SEC] = 1'b0;
        end
        if (half_sec_set) begin
            cfg_next[rtc_cfg_pkg::BIT_HALF_SEC] = 1'b1;
        end
        // Decrement happens after the access used the old pointer
        if (ptr_hit && cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2] != rtc_cfg_pkg::PTR_MIN_SEC) begin
            cfg_next[rtc_cfg_pkg::PTR_LSB +: 2] = cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2] - 2'h1;
        end
        cfg_next[rtc_cfg_pkg::BIT_SYNC] = sync_busy;
        cfg_next[14] = 1'b0;
        // Pointer cannot move between setup and access, so the captured field
        // matches the window that the access then steps past
        if (rd_setup) begin
            case (paddr)
                rtc_cfg_pkg::OFF_CFG_CAL:  prdata_next = {16'h0000, cfg_reg};
                rtc_cfg_pkg::OFF_PWR_CTRL: prdata_next = {16'h0000, pwr_reg};
                rtc_cfg_pkg::OFF_VAL_HIGH: prdata_next = (cfg_reg[rtc_cfg_pkg::PTR_LSB +: 2] ==
                                                          rtc_cfg_pkg::PTR_RSVD_YEAR) ? 32'h00000000 :
                                                         {16'h0000, val_high_in};
                rtc_cfg_pkg::OFF_VAL_LOW:  prdata_next = {16'h0000, val_low_in};
                rtc_cfg_pkg::OFF_STATUS:   prdata_next = {30'h00000000, sync_busy, pwr_ctrl_req};
                default:                   prdata_next = 32'h00000000;
            endcase
        end
    end

    // Only the power-on reset reaches these; no other reset source is wired in.
    // A user who adds a software reset must keep it away from cfg_reg and pwr_reg.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg       <= rtc_cfg_pkg::CFG_CAL_RESET;
            pwr_reg       <= rtc_cfg_pkg::PWR_RESET;
            val_wdata_reg <= 16'h0000;
            val_wptr_reg  <= 2'h0;
            hi_wr_reg     <= 1'b0;
            lo_wr_reg     <= 1'b0;
            pre_rst_reg   <= 1'b0;
            prdata_reg    <= 32'h00000000;
        end else begin
            cfg_reg       <= cfg_next;
            pwr_reg       <= pwr_next;
            val_wdata_reg <= val_wdata_next;
            val_wptr_reg  <= val_wptr_next;
            hi_wr_reg     <= hi_wr_next;
            lo_wr_reg     <= lo_wr_next;
            pre_rst_reg   <= pre_rst_next;
            prdata_reg    <= prdata_next;
        end
    end

    assign pready         = 1'b1;
    assign pslverr        = access && !known;
    assign prdata         = prdata_reg;
    assign val_wdata      = val_wdata_reg;
    assign val_wptr       = val_wptr_reg;
    assign val_high_wr    = hi_wr_reg;
    assign val_low_wr     = lo_wr_reg;
    assign prescale_reset = pre_rst_reg;
    assign module_enable  = cfg_reg[rtc_cfg_pkg::BIT_MOD_EN];
    assign output_enable  = cfg_reg[rtc_cfg_pkg::BIT_OUT_EN];
    assign cal_value      = $signed(cfg_reg[rtc_cfg_pkg::CAL_LSB +: 8]);
    assign clk_source_sel = pwr_reg[rtc_cfg_pkg::CLK_SEL_LSB +: 2];
    assign out_source_sel = pwr_reg[rtc_cfg_pkg::OUT_SEL_LSB +: 2];
    assign stab_prescale  = pwr_reg[rtc_cfg_pkg::BIT_PWC_PRE];
    assign samp_prescale  = pwr_reg[rtc_cfg_pkg::BIT_PWS_PRE];
    assign pwr_ctrl_oe    = pwr_reg[rtc_cfg_pkg::BIT_PWC_EN];
    assign pwr_ctrl_out   = pwr_reg[rtc_cfg_pkg::BIT_PWC_EN] &&
                            (pwr_ctrl_req ~^ pwr_reg[rtc_cfg_pkg::BIT_PWC_POL]);
endmodule // rtc_cfg_regs

// ---- shared/rtc_cfg_pkg.sv ----
// Register map and field layout of the clock configuration/calibration/power-control block.
// Assumes a 32-bit APB slave; 16-bit registers sit in the low half of each word.
package rtc_cfg_pkg;
    localparam logic [7:0]  OFF_CFG_CAL   = 8'h00;
    localparam logic [7:0]  OFF_PWR_CTRL  = 8'h04;
    localparam logic [7:0]  OFF_VAL_HIGH  = 8'h08;
    localparam logic [7:0]  OFF_VAL_LOW   = 8'h0C;
    localparam logic [7:0]  OFF_STATUS    = 8'h10;

    localparam int          BIT_MOD_EN    = 15;
    localparam int          BIT_WR_EN     = 13;
    localparam int          BIT_SYNC      = 12;
    localparam int          BIT_HALF_SEC  = 11;
    localparam int          BIT_OUT_EN    = 10;
    localparam int          PTR_LSB       = 8;
    localparam int          CAL_LSB       = 0;

    localparam int          BIT_PWC_EN    = 15;
    localparam int          BIT_PWC_POL   = 14;
    localparam int          BIT_PWC_PRE   = 13;
    localparam int          BIT_PWS_PRE   = 12;
    localparam int          CLK_SEL_LSB   = 10;
    localparam int          OUT_SEL_LSB   = 8;

    localparam logic [15:0] CFG_CAL_RESET = 16'h0000;
    localparam logic [15:0] PWR_RESET     = 16'h0000;
    localparam logic [15:0] PWR_WMASK     = 16'hFF00;

    localparam logic [1:0]  PTR_MIN_MONTH  = 2'h2;
    localparam logic [1:0]  PTR_WDAY_HOURS = 2'h1;
    localparam logic [1:0]  PTR_MIN_SEC    = 2'h0;
    localparam logic [1:0]  PTR_RSVD_YEAR  = 2'h3;

    localparam int          CAL_WINDOW_S  = 15;
endpackage

// ---- verification/rtc_cfg_chk.sv ----
// Port-level checker for the config/calibration/power register block.
// Bound to rtc_cfg_regs; watches a subset of its ports only.
`timescale 1ns/10ps
module rtc_cfg_chk (
    input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, // Bus side
    input wire logic [7:0]        paddr,                                              // Byte address
    input wire logic [31:0]       pwdata,                                             // Write data
    input wire logic [3:0]        pstrb,                                              // Byte strobes
    input wire logic              val_high_wr, val_low_wr, prescale_reset, module_enable, // Value side
    input wire logic [1:0]        val_wptr,                                           // Write pointer
    input wire logic signed [7:0] cal_value,                                          // Calibration
    input wire logic              pwr_ctrl_req, pwr_ctrl_out, pwr_ctrl_oe             // Power pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr     = psel && penable && pwrite;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h10);
    bus_err_a: assert property (psel && penable |-> pready && (pslverr == !mapped)) else $error("bus answer wrong");
    high_wr_a: assert property (val_high_wr |-> $past(wr && paddr == 8'h08)) else $error("stray high write");
    low_wr_a: assert property (val_low_wr |-> $past(wr && paddr == 8'h0C)) else $error("stray low write");
    presc_clr_a: assert property (prescale_reset |-> val_low_wr && val_wptr == 2'h0) else $error("bad clear");
    cal_load_a: assert property (wr && paddr == 8'h00 && pstrb[0] |=> cal_value == $past(pwdata[7:0]))
        else $error("calibration not loaded");
    en_guard_a: assert property ($changed(module_enable) |-> $past(wr && paddr == 8'h00 && pstrb[1]))
        else $error("enable changed without write");
    pwr_off_a: assert property (!pwr_ctrl_oe |-> !pwr_ctrl_out) else $error("power pin driven while off");
    pwr_follow_a: assert property (pwr_ctrl_oe && $stable(pwr_ctrl_oe) && !$past(wr) && $changed(pwr_ctrl_req)
        |-> $changed(pwr_ctrl_out)) else $error("power pin ignores request");
    cover property (val_high_wr);
    cover property (prescale_reset);
    cover property (pwr_ctrl_oe && pwr_ctrl_out);
endmodule // rtc_cfg_chk
bind rtc_cfg_regs rtc_cfg_chk chk (.*);

// ---- verification/testbench.sv ----
// Self-checking bench with a bit-level register model, compared at every transfer.
// Assumes the checker is bound to the design; the bench drives every input.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, half_sec_set = 0, sync_busy = 0;
    logic        pwr_ctrl_req = 0, pready, pslverr, err, val_high_wr, val_low_wr, prescale_reset, module_enable;
    logic        output_enable, stab_prescale, samp_prescale, pwr_ctrl_out, pwr_ctrl_oe, m_half;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic [15:0] val_high_in = 16'h0, val_low_in = 16'h0, val_wdata, m_cfg, m_pwr, hv, lv;
    logic [1:0]  val_wptr, clk_source_sel, out_source_sel;
    logic signed [7:0] cal_value;
    integer      num_errors = 0, tests_run = 0, cycles = 0, seed = 32'hf96ddcd6, i;
    rtc_cfg_regs dut (.*);
    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) begin
        val_high_in <= $random(seed);
        val_low_in <= $random(seed);
        cycles++;
        if (cycles == 2000) begin num_errors++; close_out; end
    end
    task automatic close_out;
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        hv = val_high_in; lv = val_low_in;
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr; rd = prdata;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [15:0] cfg_exp();
        return m_cfg | {3'h0, sync_busy, m_half, 11'h0};
    endfunction
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        bus(0, a, 32'h0, 4'h0);
        `CHK(rd, {16'h0, e})
    endtask
    task automatic wcfg(input logic [15:0] d, input logic [3:0] s);
        bus(1, 8'h00, {16'h0, d}, s);
        if (s[1]) begin
            if (m_cfg[13]) m_cfg[15] = d[15];
            m_cfg[13] = d[13];
            m_cfg[10:8] = d[10:8];
        end
        if (s[0]) m_cfg[7:0] = d[7:0];
        @(negedge pclk);
        `CHK({module_enable, output_enable}, {m_cfg[15], m_cfg[10]})
        `CHK(cal_value, m_cfg[7:0])
    endtask
    task automatic wval(input logic [7:0] a, input logic [15:0] d);
        logic ok;
        ok = m_cfg[13];
        bus(1, a, {16'h0, d}, 4'h3);
        @(negedge pclk);
        `CHK({val_high_wr, val_low_wr}, ok ? {a == 8'h08, a == 8'h0C} : 2'b00)
        `CHK(prescale_reset, ok && a == 8'h0C && m_cfg[9:8] == 2'h0)
        if (ok) `CHK({val_wptr, val_wdata}, {m_cfg[9:8], d})
        if (ok && a == 8'h0C && m_cfg[9:8] == 2'h0) m_half = 0;
        if (a == 8'h08 && m_cfg[9:8] != 2'h0) m_cfg[9:8] = m_cfg[9:8] - 2'h1;
    endtask
    task automatic rhigh;
        logic [1:0] p;
        p = m_cfg[9:8];
        bus(0, 8'h08, 32'h0, 4'h0);
        `CHK(rd[15:0], p == 2'h3 ? 16'h0 : hv)
        if (p != 2'h0) m_cfg[9:8] = p - 2'h1;
    endtask
    task automatic wpwr(input logic [15:0] d);
        integer j;
        bus(1, 8'h04, {16'h0, d}, 4'h3);
        m_pwr = d & 16'hFF00;
        @(negedge pclk);
        `CHK({stab_prescale, samp_prescale, clk_source_sel, out_source_sel}, m_pwr[13:8])
        for (j = 0; j < 2; j++) begin
            @(posedge pclk) pwr_ctrl_req <= j[0];
            #1 `CHK({pwr_ctrl_oe, pwr_ctrl_out}, {m_pwr[15], m_pwr[15] & (pwr_ctrl_req ~^ m_pwr[14])})
        end
    endtask
    initial begin
        m_cfg = 16'h0; m_pwr = 16'h0; m_half = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        rchk(8'h00, 16'h0);
        rchk(8'h04, 16'h0);
        wcfg(16'hA000, 4'h2);
        wcfg(16'hA000, 4'h2);
        wcfg(16'h207F, 4'h1);
        wcfg(16'h2080, 4'h1);
        for (i = 0; i < 8; i++) wcfg($random(seed), $random(seed));
        rchk(8'h00, cfg_exp());
        wcfg(16'hA300, 4'h2);
        repeat (4) rhigh;
        rchk(8'h00, cfg_exp());
        bus(0, 8'h0C, 32'h0, 4'h0);
        `CHK(rd, {16'h0, lv})
        wcfg(16'hA200, 4'h2);
        wval(8'h08, $random(seed));
        wval(8'h08, $random(seed));
        wval(8'h0C, $random(seed));
        wcfg(16'h8000, 4'h2);
        wval(8'h0C, $random(seed));
        wval(8'h08, $random(seed));
        wcfg(16'h0000, 4'h2);
        wcfg(16'h2000, 4'h2);
        @(posedge pclk) sync_busy <= 1;
        @(posedge pclk) half_sec_set <= 1;
        @(posedge pclk) half_sec_set <= 0;
        m_half = 1;
        rchk(8'h00, cfg_exp());
        wval(8'h0C, $random(seed));
        rchk(8'h00, cfg_exp());
        for (i = 0; i < 4; i++) wpwr({i[1:0], 14'($random(seed))});
        rchk(8'h04, m_pwr);
        rchk(8'h10, {14'h0, sync_busy, pwr_ctrl_req});
        bus(1, 8'h14, 32'hFFFF, 4'hF);
        `CHK(err, 1'b1)
        rchk(8'h14, 16'h0);
        `CHK(err, 1'b1)
        @(posedge pclk) presetn <= 0;
        @(posedge pclk) presetn <= 1;
        m_cfg = 16'h0; m_pwr = 16'h0; m_half = 0;
        rchk(8'h00, cfg_exp());
        close_out;
    end
endmodule // testbench
